// >>> core/lfrc_main_control.sv
/*
  main control register of the low-frequency wake-up receiver with its
  power-up and auto-zero sequencer, soft reset and decoded controls.
  assumes a byte-wide memory-mapped cpu port on sys_clk and a slow timing
  clock arriving from another domain.
*/
// What this block does
// - enable bit 7: standby or active
// - power-up starts next slow edge, one cycle
// - then 64 us auto-zero, then ready
// - bit 6 starts soft reset, reads zero
// - bit 5 picks data or carrier mode
// - bit 4 pages other registers, not controls
// - any receiver reset clears page select
// - bits 3:2 decode wake-up id length
// - bits 1:0 pick threshold pair
// - thresholds act only on carrier detection
// - carrier mode sets flag, may interrupt
`default_nettype none
module lfrc_main_control (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_read,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic slow_timing_oscillator,
  input wire logic carrier_seen,
  input wire logic carrier_detected_flag_clear,
  input wire logic carrier_interrupt_enable,
  output logic receiver_enable,
  output logic receiver_powered,
  output logic receiver_auto_zero,
  output logic receiver_ready,
  output logic soft_reset_pulse,
  output logic carrier_only_mode,
  output logic register_page_select,
  output logic [1:0] wakeup_id_select,
  output logic id_expected,
  output logic id_sixteen_bit,
  output logic id_match_either,
  output logic threshold_low_sel,
  output logic threshold_high_sel,
  output logic carrier_detected_flag,
  output logic carrier_irq
);
  logic [7:0] ctl_reg;
  logic [7:0] ctl_next;
  logic [2:0] slow_sync_reg;
  logic [9:0] az_count_reg;
  logic srst_reg;
  logic flag_reg;
  logic irq_reg;
  logic [7:0] rdata_reg;
  lfrc_pkg::lfrc_state_t state_reg;
  lfrc_pkg::lfrc_state_t state_next;

  function automatic logic [2:0] id_decode(input logic [1:0] sel);
    id_decode = {sel != lfrc_pkg::ID_NONE, sel == lfrc_pkg::ID_BOTH16,
                 sel == lfrc_pkg::ID_EITHER8};
  endfunction

  wire ctl_hit = cpu_addr == lfrc_pkg::CTL_ONE_ADDR;
  wire ctl_wr = cpu_write && ctl_hit;
  wire rd_hit = cpu_read && ctl_hit;
  wire srst_req = ctl_wr && cpu_wdata[lfrc_pkg::SOFT_RESET_BIT];
  wire slow_rise = slow_sync_reg[1] && !slow_sync_reg[2];
  wire enabled = ctl_reg[lfrc_pkg::ENABLE_BIT];
  wire az_done = az_count_reg == lfrc_pkg::AUTO_ZERO_LAST;
  wire [2:0] id_dec = id_decode(ctl_reg[lfrc_pkg::ID_SEL_HI:lfrc_pkg::ID_SEL_LO]);
  wire [1:0] thr = ctl_reg[lfrc_pkg::THR_SEL_HI:lfrc_pkg::THR_SEL_LO];
  wire carrier_mode = ctl_reg[lfrc_pkg::CARRIER_MODE_BIT];
  wire in_power_up = state_reg == lfrc_pkg::ST_POWER_UP;
  wire in_auto_zero = state_reg == lfrc_pkg::ST_AUTO_ZERO;
  // bit 6 never holds a one, masked anyway so a read can never show it
  wire [7:0] ctl_readback = ctl_reg & 8'hbf;
  // carrier mode only counts once the front end is fully settled
  wire carrier_event = state_reg == lfrc_pkg::ST_STANDBY ? 1'b0 :
    (enabled && carrier_mode && receiver_ready && carrier_seen);

  // soft reset wins over the written fields, which return to zero
  always_comb begin
    ctl_next = ctl_reg;
    if (srst_req) begin
      ctl_next = lfrc_pkg::CTL_ONE_RESET;
    end else if (ctl_wr) begin
      ctl_next = cpu_wdata;
      ctl_next[lfrc_pkg::SOFT_RESET_BIT] = 1'b0;
    end
  end

  // sequencer; the slow clock edge is only seen after two sync stages
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lfrc_pkg::ST_STANDBY: begin
        if (enabled) state_next = lfrc_pkg::ST_WAIT_EDGE;
      end
      lfrc_pkg::ST_WAIT_EDGE: begin
        if (slow_rise) state_next = lfrc_pkg::ST_POWER_UP;
      end
      lfrc_pkg::ST_POWER_UP: begin
        if (slow_rise) state_next = lfrc_pkg::ST_AUTO_ZERO;
      end
      lfrc_pkg::ST_AUTO_ZERO: begin
        if (az_done) state_next = lfrc_pkg::ST_READY;
      end
      // ready is held so power-up and auto-zero run once per enable
      lfrc_pkg::ST_READY: begin
        state_next = lfrc_pkg::ST_READY;
      end
      default: state_next = lfrc_pkg::ST_STANDBY;
    endcase
    if (!enabled || srst_reg) state_next = lfrc_pkg::ST_STANDBY;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctl_reg <= lfrc_pkg::CTL_ONE_RESET;
      slow_sync_reg <= 3'h0;
      state_reg <= lfrc_pkg::ST_STANDBY;
      az_count_reg <= 10'h000;
      srst_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      slow_sync_reg <= {slow_sync_reg[1:0], slow_timing_oscillator};
      state_reg <= state_next;
      az_count_reg <= (state_reg == lfrc_pkg::ST_AUTO_ZERO && !az_done) ?
        10'(az_count_reg + 10'h001) : 10'h000;
      srst_reg <= srst_req;
    end
  end

  // ready persists after auto-zero until disable or soft reset
  logic ready_reg;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ready_reg <= 1'b0;
    end else if (!enabled || srst_reg) begin
      ready_reg <= 1'b0;
    end else if (state_reg == lfrc_pkg::ST_AUTO_ZERO && az_done) begin
      ready_reg <= 1'b1;
    end
  end
  assign receiver_ready = ready_reg;

  // set wins over clear so a carrier in the clear cycle is kept
  wire flag_next = carrier_event || (flag_reg && !carrier_detected_flag_clear);
  // irq follows the next flag value so it rises in the same cycle as the flag
  always_ff @(posedge sys_clk) begin
    if (!reset_n || srst_reg) begin
      flag_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      irq_reg <= flag_next && carrier_interrupt_enable;
    end
  end

  // soft reset bit reads zero; unmapped reads give zero
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_hit) begin
      rdata_reg <= ctl_readback;
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  // sequencer status and strobe outputs, all from flops
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      receiver_enable <= 1'b0;
      receiver_powered <= 1'b0;
      receiver_auto_zero <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      receiver_enable <= enabled;
      receiver_powered <= in_power_up;
      receiver_auto_zero <= in_auto_zero;
      soft_reset_pulse <= srst_req;
    end
  end

  // raw field outputs; they lag the register by one cycle
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      carrier_only_mode <= 1'b0;
      register_page_select <= 1'b0;
      wakeup_id_select <= 2'h0;
    end else begin
      carrier_only_mode <= carrier_mode;
      register_page_select <= ctl_reg[lfrc_pkg::PAGE_BIT];
      wakeup_id_select <= ctl_reg[lfrc_pkg::ID_SEL_HI:lfrc_pkg::ID_SEL_LO];
    end
  end

  // decoded outputs share the field's cycle so they never disagree with it
  // thresholds feed only the carrier detector, never the message path
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      id_expected <= 1'b0;
      id_sixteen_bit <= 1'b0;
      id_match_either <= 1'b0;
      threshold_low_sel <= 1'b0;
      threshold_high_sel <= 1'b0;
    end else begin
      id_expected <= id_dec[2];
      id_sixteen_bit <= id_dec[1];
      id_match_either <= id_dec[0];
      threshold_low_sel <= thr == lfrc_pkg::THR_LOW;
      threshold_high_sel <= thr == lfrc_pkg::THR_HIGH;
    end
  end
  assign cpu_rdata = rdata_reg;
  assign carrier_detected_flag = flag_reg;
  assign carrier_irq = irq_reg;
endmodule
`default_nettype wire

// >>> include/lfrc_pkg.sv
/*
  package for the receiver main control register: offset, field positions,
  reset value and timing counts.
  assumes a 10 MHz system clock and a slow timing clock near 1 kHz.
*/
`default_nettype none
package lfrc_pkg;
  localparam logic [7:0] CTL_ONE_ADDR = 8'h20;
  localparam logic [7:0] CTL_TWO_ADDR = 8'h21;
  localparam logic [7:0] CTL_ONE_RESET = 8'h00;
  localparam int ENABLE_BIT = 7;
  localparam int SOFT_RESET_BIT = 6;
  localparam int CARRIER_MODE_BIT = 5;
  localparam int PAGE_BIT = 4;
  localparam int ID_SEL_HI = 3;
  localparam int ID_SEL_LO = 2;
  localparam int THR_SEL_HI = 1;
  localparam int THR_SEL_LO = 0;
  localparam logic [1:0] ID_NONE = 2'h0;
  localparam logic [1:0] ID_LOW8 = 2'h1;
  localparam logic [1:0] ID_BOTH16 = 2'h2;
  localparam logic [1:0] ID_EITHER8 = 2'h3;
  localparam logic [1:0] THR_LOW = 2'h1;
  localparam logic [1:0] THR_HIGH = 2'h2;
  localparam int CLK_HZ = 10000000;
  localparam int AUTO_ZERO_US = 64;
  localparam int AUTO_ZERO_CYC = (AUTO_ZERO_US * (CLK_HZ / 1000000) > 0) ?
    AUTO_ZERO_US * (CLK_HZ / 1000000) : 1;
  localparam logic [9:0] AUTO_ZERO_LAST = 10'(AUTO_ZERO_CYC - 1);
  typedef enum logic [4:0] {
    ST_STANDBY = 5'b00001,
    ST_WAIT_EDGE = 5'b00010,
    ST_POWER_UP = 5'b00100,
    ST_AUTO_ZERO = 5'b01000,
    ST_READY = 5'b10000
  } lfrc_state_t;
endpackage
`default_nettype wire

// >>> test/lfrc_chk.sv
/* assertions on the receiver main control register ports.
   assumes it is bound onto lfrc_main_control. */
`default_nettype none
module lfrc_chk (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_write,
  input wire logic cpu_read,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic receiver_enable,
  input wire logic receiver_auto_zero,
  input wire logic receiver_ready,
  input wire logic soft_reset_pulse,
  input wire logic register_page_select,
  input wire logic [1:0] wakeup_id_select,
  input wire logic id_sixteen_bit,
  input wire logic id_match_either,
  input wire logic threshold_low_sel
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic wr = cpu_write && cpu_addr == lfrc_pkg::CTL_ONE_ADDR;
  // a soft reset write drops its other bits, so only plain writes predict fields
  wire logic pw = wr && !cpu_wdata[6];
  AST_RD_B6: assert property (cpu_read |=> !cpu_rdata[6])
    else $error("soft reset bit read as one");
  AST_SRST_PULSE: assert property (wr && cpu_wdata[6] |=> soft_reset_pulse)
    else $error("no soft reset pulse");
  AST_SRST_ZERO: assert property (soft_reset_pulse |=> !receiver_enable && !register_page_select)
    else $error("fields survive soft reset");
  AST_EN: assert property (pw |-> ##2 receiver_enable == $past(cpu_wdata[7], 2))
    else $error("enable output wrong");
  AST_PAGE: assert property (pw |-> ##2 register_page_select == $past(cpu_wdata[4], 2))
    else $error("page select wrong");
  AST_ID: assert property (id_sixteen_bit == (wakeup_id_select == 2'h2) && id_match_either == (wakeup_id_select == 2'h3))
    else $error("id decode wrong");
  AST_THR: assert property (pw |-> ##2 threshold_low_sel == ($past(cpu_wdata[1:0], 2) == 2'h1))
    else $error("threshold select wrong");
  AST_RDY: assert property ($rose(receiver_ready) |-> $past(receiver_auto_zero) && receiver_enable)
    else $error("ready without auto-zero");
  cover property (soft_reset_pulse);
  cover property ($rose(receiver_ready));
  cover property (pw ##2 threshold_low_sel);
endmodule
bind lfrc_main_control lfrc_chk u_chk (.*);
`default_nettype wire

// >>> test/tb_top.sv
/* bench for the receiver main control register.
   assumes the package, design and checker are compiled first. */
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, reset_n = 0, cpu_write = 0, cpu_read = 0, carrier_seen = 0;
  logic carrier_detected_flag_clear = 0, carrier_interrupt_enable = 0;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, cpu_rdata;
  logic [10:0] slow_cnt = 11'h000;
  logic [1:0] k, wakeup_id_select;
  logic receiver_enable, receiver_powered, receiver_auto_zero, receiver_ready;
  logic soft_reset_pulse, carrier_only_mode, register_page_select, id_expected;
  logic id_sixteen_bit, id_match_either, threshold_low_sel, threshold_high_sel;
  logic carrier_detected_flag, carrier_irq;
  wire logic slow_timing_oscillator = slow_cnt[10];
  int fail_count = 0, tests_run = 0;
  lfrc_main_control dut (.*);
  initial forever #50 sys_clk = ~sys_clk;
  // slow clock much faster than the real one to keep the run short
  always @(posedge sys_clk) slow_cnt <= slow_cnt + 11'h001;
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_write <= 1'b1;
    @(posedge sys_clk);
    cpu_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    cpu_addr <= a;
    cpu_read <= 1'b1;
    @(posedge sys_clk);
    cpu_read <= 1'b0;
    #1 chk("rdata", e, cpu_rdata);
  endtask
  task automatic chk_count(input string s, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // counts status outputs until ready, bounded so a hang still ends
  task automatic wait_ready;
    int pw_cnt;
    int az_cnt;
    pw_cnt = 0;
    az_cnt = 0;
    for (int i = 0; i < 8000 && receiver_ready !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
      if (receiver_powered === 1'b1) pw_cnt++;
      if (receiver_auto_zero === 1'b1) az_cnt++;
    end
    chk("ready", 8'h01, {7'h00, receiver_ready});
    // one slow period of the bench's oscillator is 2048 system clocks
    chk_count("power-up cycles", 16'h0800, 16'(pw_cnt));
    chk_count("auto-zero cycles", 16'(lfrc_pkg::AUTO_ZERO_CYC), 16'(az_cnt));
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      wr(8'h20, {4'h3, k, k});
      repeat (2) @(posedge sys_clk);
      #1 chk("decode", {2'b11, k != 0, k == 2, k == 3, k == 1, k == 2, 1'b0}, {carrier_only_mode,
        register_page_select, id_expected, id_sixteen_bit, id_match_either, threshold_low_sel,
        threshold_high_sel, 1'b0});
      chk("id select", {6'h00, k}, {6'h00, wakeup_id_select});
      rd(8'h20, {4'h3, k, k});
    end
    $display("field test done");
    wr(8'h20, 8'hF5);
    #1 chk("pulse", 8'h01, {7'h00, soft_reset_pulse});
    rd(8'h20, 8'h00);
    chk("page", 8'h00, {7'h00, register_page_select});
    $display("soft reset test done");
    wr(8'h20, 8'hA0);
    wait_ready;
    @(posedge sys_clk);
    carrier_interrupt_enable <= 1'b1;
    carrier_seen <= 1'b1;
    @(posedge sys_clk);
    carrier_seen <= 1'b0;
    #1 chk("carrier", 8'h03, {6'h00, carrier_detected_flag, carrier_irq});
    @(posedge sys_clk);
    carrier_detected_flag_clear <= 1'b1;
    carrier_seen <= 1'b1;
    @(posedge sys_clk);
    carrier_seen <= 1'b0;
    #1 chk("set wins", 8'h01, {7'h00, carrier_detected_flag});
    @(posedge sys_clk);
    carrier_detected_flag_clear <= 1'b0;
    #1 chk("flag clear", 8'h00, {6'h00, carrier_detected_flag, carrier_irq});
    $display("carrier test done");
    wr(8'h20, 8'h00);
    repeat (3) @(posedge sys_clk);
    #1 chk("standby", 8'h00, {6'h00, receiver_enable, receiver_ready});
    $display("disable test done");
    repeat (4096) @(posedge sys_clk);
    wr(8'h20, 8'h80);
    wait_ready;
    @(posedge sys_clk);
    carrier_seen <= 1'b1;
    @(posedge sys_clk);
    carrier_seen <= 1'b0;
    #1 chk("data mode", 8'h00, {6'h00, carrier_detected_flag, carrier_irq});
    wr(8'h20, 8'h40);
    repeat (2) @(posedge sys_clk);
    #1 chk("soft standby", 8'h00, {6'h00, receiver_enable, receiver_ready});
    $display("re-enable test done");
    wrap_up;
  end
  initial begin
    #3000000;
    fail_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
